// file: shared/sbo_pkg.sv
// ==========================================================
// Constants, types and field layout for the burst-order and row-activation block.
// Assumes one 125 MHz clock shared with the memory controller logic.
//
// Operation
// - Mode bit burst_type_bit picks sequential (0) or interleaved (1) order for bursts.
// - Sequential bursts count up from start column, wrapping in block; full page wraps page.
// - Interleaved bursts use start low bits XOR a beat counter; full page unsupported.
// - Read at edge n with latency m gives valid first data by edge n+m.
// - Data outputs start driving from edge n+m-1 after a read at edge n.
// - Write burst mode bit set makes every write single-location; reads keep length.
// - Mode layout: length 2:0, type 3, latency 6:4, mode 8:7, write mode 9.
// - Fixed bursts stay inside an aligned block of burst-length columns, wrapping there.
`default_nettype none
package sbo_pkg;

   localparam int COL_W  = 9;
   localparam int ROW_W  = 12;
   localparam int BANK_W = 2;
   localparam int NBANK  = 4;
   localparam int DQ_W   = 16;
   localparam int MODE_W = 12;

   // Mode register layout
   localparam int MODE_LEN_LO  = 0;
   localparam int MODE_LEN_HI  = 2;
   localparam int MODE_TYPE    = 3;
   localparam int MODE_LAT_LO  = 4;
   localparam int MODE_LAT_HI  = 6;
   localparam int MODE_OP_LO   = 7;
   localparam int MODE_OP_HI   = 8;
   localparam int MODE_WBM     = 9;
   localparam logic [MODE_W-1:0] MODE_RESET = 12'h0_020;

   // Burst length codes
   localparam logic [2:0] BL_1    = 3'h0;
   localparam logic [2:0] BL_2    = 3'h1;
   localparam logic [2:0] BL_4    = 3'h2;
   localparam logic [2:0] BL_8    = 3'h3;
   localparam logic [2:0] BL_PAGE = 3'h7;

   // Read latency codes
   localparam logic [2:0] LAT_2 = 3'h2;
   localparam logic [2:0] LAT_3 = 3'h3;

   localparam logic [COL_W-1:0] COL_ZERO = 9'h000;
   localparam logic [COL_W-1:0] COL_ONE  = 9'h001;
   localparam logic [COL_W-1:0] MASK_1   = 9'h000;
   localparam logic [COL_W-1:0] MASK_2   = 9'h001;
   localparam logic [COL_W-1:0] MASK_4   = 9'h003;
   localparam logic [COL_W-1:0] MASK_8   = 9'h007;
   localparam logic [COL_W-1:0] MASK_PG  = 9'h1ff;

   typedef enum logic [2:0] {
      SBO_CMD_NOP,
      SBO_CMD_ACTIVE,
      SBO_CMD_READ,
      SBO_CMD_WRITE,
      SBO_CMD_PRECHARGE,
      SBO_CMD_STOP,
      SBO_CMD_MODE
   } sbo_cmd_t;

   typedef struct packed {
      logic [BANK_W-1:0] bank;
      logic [ROW_W-1:0]  row;
      logic [COL_W-1:0]  col;
      logic              write;
   } sbo_beat_t;

endpackage
`default_nettype wire

// file: shared/sbo_beat_if.sv
// ==========================================================
// Valid/ready channel carrying one array access per beat.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface sbo_beat_if;
   import sbo_pkg::*;
   logic      valid;
   logic      ready;
   sbo_beat_t data;
   modport src (output valid, output data, input ready);
   modport dst (input valid, input data, output ready);
endinterface
`default_nettype wire

// file: verilog/sbo_buf2.sv
// ==========================================================
// Two-entry buffer for beat accesses, registered storage, valid/ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module sbo_buf2 (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rstn,
   // Channels
   sbo_beat_if.dst   in_ch,
   sbo_beat_if.src   out_ch
);
   import sbo_pkg::*;

   typedef struct packed {
      sbo_beat_t [1:0] mem;
      logic            rd;
      logic            wr;
      logic [1:0]      count;
   } sbo_buf_state_t;

   sbo_buf_state_t state;
   sbo_buf_state_t next_state;
   logic           push;
   logic           pop;

   // Full and empty are honest: ready drops once both entries hold words
   assign in_ch.ready  = (state.count != 2'h2);
   assign out_ch.valid = (state.count != 2'h0);
   assign out_ch.data  = state.mem[state.rd];
   assign push = in_ch.valid && in_ch.ready;
   assign pop  = out_ch.valid && out_ch.ready;

   always_comb begin
      next_state = state;
      if (push) begin
         next_state.mem[state.wr] = in_ch.data;
         next_state.wr = ~state.wr;
      end
      if (pop) begin
         next_state.rd = ~state.rd;
      end
      if (push && !pop) begin
         next_state.count = state.count + 2'h1;
      end else if (pop && !push) begin
         next_state.count = state.count - 2'h1;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

endmodule
`default_nettype wire

// file: verilog/sbo_core.sv
// ==========================================================
// Burst column sequencer, open-row tracking and read-data output timing.
// Assumes the controller shares this clock and keeps its own command spacing.
`timescale 1ns/1ps
`default_nettype none
module sbo_core (
   // Clock and reset
   input  wire logic                          clk,
   input  wire logic                          rstn,
   // Command from controller
   input  wire sbo_pkg::sbo_cmd_t             cmd,
   input  wire logic [sbo_pkg::BANK_W-1:0]    cmd_bank,
   input  wire logic [sbo_pkg::ROW_W-1:0]     cmd_addr,
   // Array access port
   output logic                               array_valid,
   input  wire logic                          array_ready,
   output logic [sbo_pkg::BANK_W-1:0]         array_bank,
   output logic [sbo_pkg::ROW_W-1:0]          array_row,
   output logic [sbo_pkg::COL_W-1:0]          array_col,
   output logic                               array_write,
   input  wire logic [sbo_pkg::DQ_W-1:0]      array_rdata,
   // Data pins
   output logic [sbo_pkg::DQ_W-1:0]           dq_out,
   output logic                               dq_oe_n,
   // Status
   output logic [sbo_pkg::MODE_W-1:0]         mode_value,
   output logic [sbo_pkg::NBANK-1:0]          bank_open,
   output logic                               burst_busy,
   output logic                               cmd_error
);
   import sbo_pkg::*;

   typedef enum logic {ST_IDLE, ST_BURST} sbo_st_t;

   typedef struct packed {
      sbo_st_t                      st;
      logic [MODE_W-1:0]            mode;
      logic [NBANK-1:0]             open;
      logic [NBANK-1:0][ROW_W-1:0]  row;
      logic [BANK_W-1:0]            bank;
      logic [COL_W-1:0]             start;
      logic [COL_W-1:0]             cnt;
      logic [COL_W-1:0]             mask;
      logic                         inter;
      logic                         write;
      logic                         pipe;
      logic [DQ_W-1:0]              pdata;
      logic [DQ_W-1:0]              dq;
      logic                         oe_n;
      logic                         err;
   } sbo_core_state_t;

   sbo_core_state_t state;
   sbo_core_state_t next_state;
   sbo_beat_if      gen_ch ();
   sbo_beat_if      arr_ch ();

   logic [NBANK-1:0] act_hit;
   logic [NBANK-1:0] pre_hit;
   logic             col_cmd;
   logic [COL_W-1:0] len_mask;
   logic [COL_W-1:0] beat_col;
   logic [COL_W-1:0] seed;
   logic [COL_W-1:0] off;
   logic [COL_W-1:0] cur_mask;
   logic             cur_inter;
   logic             lat2;
   logic             taken;
   logic             rd_taken;

   // Decoded mode fields
   assign lat2 = (state.mode[MODE_LAT_HI:MODE_LAT_LO] == LAT_2);

   // Per-bank open/close decode
   genvar gb;
   generate
      for (gb = 0; gb < NBANK; gb++) begin : g_bank
         assign act_hit[gb] = (cmd == SBO_CMD_ACTIVE) && (cmd_bank == BANK_W'(gb));
         assign pre_hit[gb] = (cmd == SBO_CMD_PRECHARGE) && (cmd_bank == BANK_W'(gb));
      end
   endgenerate

   // Length decode; reserved codes fall back to single access
   always_comb begin
      if (state.mode[MODE_LEN_HI:MODE_LEN_LO] == BL_2) begin
         len_mask = MASK_2;
      end else if (state.mode[MODE_LEN_HI:MODE_LEN_LO] == BL_4) begin
         len_mask = MASK_4;
      end else if (state.mode[MODE_LEN_HI:MODE_LEN_LO] == BL_8) begin
         len_mask = MASK_8;
      end else if (state.mode[MODE_LEN_HI:MODE_LEN_LO] == BL_PAGE) begin
         len_mask = MASK_PG;
      end else begin
         len_mask = MASK_1;
      end
   end

   // A column command only starts when its bank holds an open row
   assign col_cmd = ((cmd == SBO_CMD_READ) || (cmd == SBO_CMD_WRITE))
                    && state.open[cmd_bank];

   // Beat column: new command seeds counter at zero, else continue
   always_comb begin
      if (col_cmd) begin
         seed      = cmd_addr[COL_W-1:0];
         off       = COL_ZERO;
         cur_inter = state.mode[MODE_TYPE] && (len_mask != MASK_PG);
         if ((cmd == SBO_CMD_WRITE) && state.mode[MODE_WBM]) begin
            cur_mask = MASK_1;
         end else begin
            cur_mask = len_mask;
         end
      end else begin
         seed      = state.start;
         off       = state.cnt;
         cur_inter = state.inter;
         cur_mask  = state.mask;
      end
      if (cur_inter) begin
         beat_col = (seed & ~cur_mask) | ((seed ^ off) & cur_mask);
      end else begin
         beat_col = (seed & ~cur_mask) | ((seed + off) & cur_mask);
      end
   end

   // Generator feeds the buffer one beat per clock while it has room
   assign gen_ch.valid      = col_cmd || (state.st == ST_BURST);
   assign gen_ch.data.col   = beat_col;
   assign gen_ch.data.bank  = col_cmd ? cmd_bank : state.bank;
   assign gen_ch.data.row   = state.row[gen_ch.data.bank];
   assign gen_ch.data.write = col_cmd ? (cmd == SBO_CMD_WRITE) : state.write;
   assign taken             = gen_ch.valid && gen_ch.ready;

   sbo_buf2 u_buf (
      .clk    (clk),
      .rstn   (rstn),
      .in_ch  (gen_ch),
      .out_ch (arr_ch)
   );

   assign array_valid  = arr_ch.valid;
   assign arr_ch.ready = array_ready;
   assign array_bank   = arr_ch.data.bank;
   assign array_row    = arr_ch.data.row;
   assign array_col    = arr_ch.data.col;
   assign array_write  = arr_ch.data.write;
   assign rd_taken     = arr_ch.valid && array_ready && !arr_ch.data.write;

   always_comb begin
      next_state = state;
      next_state.err = 1'b0;
      if (cmd == SBO_CMD_MODE) begin
         next_state.mode = cmd_addr[MODE_W-1:0];
      end
      for (int b = 0; b < NBANK; b++) begin
         if (act_hit[b]) begin
            next_state.open[b] = 1'b1;
            next_state.row[b]  = cmd_addr;
         end else if (pre_hit[b]) begin
            next_state.open[b] = 1'b0;
         end
      end
      if (((cmd == SBO_CMD_READ) || (cmd == SBO_CMD_WRITE)) && !col_cmd) begin
         next_state.err = 1'b1;
      end
      // Counter steps only when the beat is taken, so a stall loses no column
      case (state.st)
         ST_IDLE: begin
            if (col_cmd && taken) begin
               next_state.start = cmd_addr[COL_W-1:0];
               next_state.bank  = cmd_bank;
               next_state.write = (cmd == SBO_CMD_WRITE);
               next_state.inter = cur_inter;
               next_state.mask  = cur_mask;
               next_state.cnt   = COL_ONE;
               next_state.st    = (cur_mask == MASK_1) ? ST_IDLE : ST_BURST;
            end
         end
         ST_BURST: begin
            if (col_cmd) begin
               if (taken) begin
                  next_state.start = cmd_addr[COL_W-1:0];
                  next_state.bank  = cmd_bank;
                  next_state.write = (cmd == SBO_CMD_WRITE);
                  next_state.inter = cur_inter;
                  next_state.mask  = cur_mask;
                  next_state.cnt   = COL_ONE;
                  next_state.st    = (cur_mask == MASK_1) ? ST_IDLE : ST_BURST;
               end
            end else if ((cmd == SBO_CMD_STOP) || (pre_hit[state.bank])) begin
               next_state.st = ST_IDLE;
            end else if (taken) begin
               next_state.cnt = state.cnt + COL_ONE;
               // Full page never ends by itself; it wraps until stopped
               if ((state.cnt == state.mask) && (state.mask != MASK_PG)) begin
                  next_state.st = ST_IDLE;
               end
            end
         end
         default: begin
            next_state.st = ST_IDLE;
         end
      endcase
      // Output timing: array answers in the cycle it takes the beat
      next_state.pipe  = rd_taken && !lat2;
      next_state.pdata = array_rdata;
      if (lat2) begin
         next_state.dq   = array_rdata;
         next_state.oe_n = !rd_taken;
      end else begin
         next_state.dq   = state.pdata;
         next_state.oe_n = !state.pipe;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state      <= '0;
         state.mode <= MODE_RESET;
         state.oe_n <= 1'b1;
      end else begin
         state <= next_state;
      end
   end

   assign dq_out     = state.dq;
   assign dq_oe_n    = state.oe_n;
   assign mode_value = state.mode;
   assign bank_open  = state.open;
   assign burst_busy = (state.st == ST_BURST);
   assign cmd_error  = state.err;

endmodule
`default_nettype wire

// file: test/sbo_core_asserts.sv
// ==========================================================
// Checker for the burst sequencer, watching top-level ports only.
// Assumes one clock and rstn as its asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module sbo_core_asserts (
   // Clock and reset
   input wire logic                       clk,
   input wire logic                       rstn,
   // Command
   input wire sbo_pkg::sbo_cmd_t          cmd,
   input wire logic [sbo_pkg::BANK_W-1:0] cmd_bank,
   input wire logic [sbo_pkg::ROW_W-1:0]  cmd_addr,
   // Array side
   input wire logic                       array_valid,
   input wire logic                       array_ready,
   input wire logic [sbo_pkg::COL_W-1:0]  array_col,
   // Pins and status
   input wire logic                       dq_oe_n,
   input wire logic [sbo_pkg::MODE_W-1:0] mode_value,
   input wire logic [sbo_pkg::NBANK-1:0]  bank_open,
   input wire logic                       burst_busy,
   input wire logic                       cmd_error
);
   import sbo_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // ==========================================================
   // Read start with nothing in flight
   logic rd_ok;
   assign rd_ok = cmd == SBO_CMD_READ && bank_open[cmd_bank] && !array_valid && dq_oe_n;
   property p_first_beat;
      rd_ok |=> array_valid && array_col == $past(cmd_addr[8:0]);
   endproperty
   a_first_beat: assert property (p_first_beat) else $error("first beat column wrong");
   property p_oe_lat2;
      rd_ok && mode_value[6:4] == LAT_2 && array_ready ##1 array_ready |-> ##1 !dq_oe_n;
   endproperty
   a_oe_lat2: assert property (p_oe_lat2) else $error("latency two data late");
   property p_oe_lat3;
      rd_ok && mode_value[6:4] == LAT_3 && array_ready ##1 array_ready[*2] |-> ##1 !dq_oe_n;
   endproperty
   a_oe_lat3: assert property (p_oe_lat3) else $error("latency three data late");
   // Earlier commands could legally own the pins, so two idle cycles are required first
   property p_no_early;
      rd_ok && $past(cmd) == SBO_CMD_NOP && $past(cmd, 2) == SBO_CMD_NOP
         |=> dq_oe_n ##1 (dq_oe_n || mode_value[6:4] == LAT_2);
   endproperty
   a_no_early: assert property (p_no_early) else $error("data pins driven early");
   property p_seq_step;
      array_valid && array_ready && burst_busy && cmd == SBO_CMD_NOP && mode_value[3:0] == 4'h3
         |=> array_valid && array_col[2:0] == $past(array_col[2:0]) + 3'h1
             && array_col[8:3] == $past(array_col[8:3]);
   endproperty
   a_seq_step: assert property (p_seq_step) else $error("sequential step wrong");
   property p_single_write;
      (cmd == SBO_CMD_WRITE && bank_open[cmd_bank] && mode_value[9] && !array_valid && array_ready)
         ##1 (cmd == SBO_CMD_NOP && array_ready) |-> array_valid ##1 !array_valid;
   endproperty
   a_single_write: assert property (p_single_write) else $error("write not single");
   property p_closed_bank;
      (cmd == SBO_CMD_READ || cmd == SBO_CMD_WRITE) && !bank_open[cmd_bank] |=> cmd_error;
   endproperty
   a_closed_bank: assert property (p_closed_bank) else $error("closed bank not flagged");
   property p_mode_load;
      cmd == SBO_CMD_MODE |=> mode_value == $past(cmd_addr);
   endproperty
   a_mode_load: assert property (p_mode_load) else $error("mode value not loaded");
endmodule
`default_nettype wire

// file: test/sbo_array_model.sv
// ==========================================================
// Array-side partner: takes beats, returns address-tagged data.
// Assumes the bench drives stall off the falling edge.
`timescale 1ns/1ps
`default_nettype none
module sbo_array_model (
   // Clock
   input  wire logic                       clk,
   // Beat channel
   input  wire logic                       array_valid,
   output logic                            array_ready,
   input  wire logic [sbo_pkg::BANK_W-1:0] array_bank,
   input  wire logic [sbo_pkg::ROW_W-1:0]  array_row,
   input  wire logic [sbo_pkg::COL_W-1:0]  array_col,
   output logic [sbo_pkg::DQ_W-1:0]        array_rdata,
   // Bench control
   input  wire logic                       stall
);
   import sbo_pkg::*;
   logic tick = 1'b0;
   always @(posedge clk) tick <= ~tick;
   assign array_ready = ~stall;
   // Idle data flips every cycle so a mistimed sample cannot match
   assign array_rdata = array_valid ? {array_bank, array_row[4:0], array_col} : {8{tick, ~tick}};
endmodule
`default_nettype wire

// file: test/sbo_core_tb.sv
// ==========================================================
// Bench for the burst sequencer: commands, read timing, beat order.
// Assumes sbo_core, its buffer, the array model and checker compile first.
`timescale 1ns/1ps
`default_nettype none
module sbo_core_tb;
   import sbo_pkg::*;
   logic                 clk = 1'b0;
   logic                 rstn = 1'b0;
   sbo_cmd_t             cmd = SBO_CMD_NOP;
   logic [BANK_W-1:0]    cmd_bank = 2'h0;
   logic [ROW_W-1:0]     cmd_addr = 12'h000;
   logic                 stall = 1'b0;
   logic                 array_valid, array_ready, array_write, dq_oe_n, burst_busy, cmd_error;
   logic [BANK_W-1:0]    array_bank;
   logic [ROW_W-1:0]     array_row;
   logic [COL_W-1:0]     array_col;
   logic [DQ_W-1:0]      array_rdata, dq_out;
   logic [MODE_W-1:0]    mode_value;
   logic [NBANK-1:0]     bank_open;
   int                   errors = 0;
   int                   n_checks = 0;
   logic [COL_W-1:0]     taken[$];
   logic [ROW_W-1:0]     rows[2] = '{12'h123, 12'h0a5};
   always #4 clk = ~clk;
   always @(posedge clk) if (array_valid && array_ready) taken.push_back(array_col);
   sbo_core u_dut (.clk, .rstn, .cmd, .cmd_bank, .cmd_addr, .array_valid, .array_ready,
      .array_bank, .array_row, .array_col, .array_write, .array_rdata, .dq_out, .dq_oe_n,
      .mode_value, .bank_open, .burst_busy, .cmd_error);
   sbo_array_model u_arr (.clk, .array_valid, .array_ready, .array_bank, .array_row,
      .array_col, .array_rdata, .stall);
   // ==========================================================
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up;
      if (errors == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // One command for one cycle, then idle
   task automatic issue(input sbo_cmd_t c, input logic [BANK_W-1:0] b, input logic [11:0] a);
      @(negedge clk);
      cmd = c;
      cmd_bank = b;
      cmd_addr = a;
      @(negedge clk);
      cmd = SBO_CMD_NOP;
   endtask
   task automatic set_mode(input logic [2:0] bl, input logic ilv, input logic [2:0] lat,
                           input logic wbm);
      issue(SBO_CMD_MODE, 2'h0, {2'h0, wbm, 2'h0, lat, ilv, bl});
   endtask
   task automatic wait_idle;
      int i;
      for (i = 0; i < 40 && (burst_busy !== 1'b0 || array_valid !== 1'b0 || dq_oe_n !== 1'b1); i++)
         @(negedge clk);
      if (i == 40) begin
         errors++;
         wrap_up();
      end
   endtask
   function automatic logic [COL_W-1:0] ecol(input logic [COL_W-1:0] s, input int k,
                                             input logic [COL_W-1:0] msk, input logic ilv);
      logic [COL_W-1:0] kk;
      kk = COL_W'(k);
      return (s & ~msk) | ((ilv ? (s ^ kk) : (s + kk)) & msk);
   endfunction
   // Read burst, checking pin timing and each beat's data
   task automatic rd(input logic [BANK_W-1:0] b, input logic [COL_W-1:0] s,
                     input logic [COL_W-1:0] msk, input logic ilv, input int m, input int nb);
      issue(SBO_CMD_READ, b, {3'h0, s});
      repeat (m - 2) @(negedge clk);
      chk(dq_oe_n, 1'b1);
      for (int k = 0; k < nb; k++) begin
         @(negedge clk);
         chk(dq_oe_n, 1'b0);
         chk(dq_out, {b, rows[b][4:0], ecol(s, k, msk, ilv)});
      end
      if (msk == MASK_PG) begin
         issue(SBO_CMD_STOP, b, 12'h000);
      end else begin
         @(negedge clk);
         chk(dq_oe_n, 1'b1);
      end
      wait_idle();
   endtask
   // ==========================================================
   initial begin
      repeat (8) @(negedge clk);
      rstn = 1'b1;
      chk(mode_value, MODE_RESET);
      chk(bank_open, 4'h0);
      issue(SBO_CMD_READ, 2'h2, 12'h004);
      chk(cmd_error, 1'b1);
      issue(SBO_CMD_ACTIVE, 2'h0, rows[0]);
      issue(SBO_CMD_ACTIVE, 2'h1, rows[1]);
      repeat (3) @(negedge clk);
      chk(bank_open, 4'h3);
      set_mode(BL_4, 1'b0, LAT_2, 1'b0);
      rd(2'h0, 9'h005, MASK_4, 1'b0, 2, 4);
      set_mode(BL_4, 1'b1, LAT_3, 1'b0);
      rd(2'h1, 9'h011, MASK_4, 1'b1, 3, 4);
      set_mode(BL_8, 1'b1, LAT_2, 1'b0);
      rd(2'h0, 9'h0a3, MASK_8, 1'b1, 2, 8);
      set_mode(BL_8, 1'b0, LAT_3, 1'b0);
      rd(2'h1, 9'h00d, MASK_8, 1'b0, 3, 8);
      set_mode(BL_2, 1'b1, LAT_2, 1'b0);
      rd(2'h0, 9'h1ff, MASK_2, 1'b1, 2, 2);
      set_mode(BL_1, 1'b0, LAT_3, 1'b0);
      rd(2'h1, 9'h07e, MASK_1, 1'b0, 3, 1);
      // Interleaved full page is unsupported and runs sequentially
      set_mode(BL_PAGE, 1'b1, LAT_2, 1'b0);
      rd(2'h0, 9'h1fe, MASK_PG, 1'b0, 2, 4);
      // Stalled write burst: the buffer holds two beats, the counter waits, and all eight beats must arrive in order
      set_mode(BL_8, 1'b0, LAT_2, 1'b0);
      taken.delete();
      stall = 1'b1;
      issue(SBO_CMD_WRITE, 2'h1, 12'h0f3);
      chk({array_valid, array_write, burst_busy}, 3'h7);
      repeat (6) @(negedge clk);
      stall = 1'b0;
      wait_idle();
      chk(taken.size(), 8);
      for (int k = 0; k < 8; k++) chk(taken[k], ecol(9'h0f3, k, MASK_8, 1'b0));
      set_mode(BL_8, 1'b0, LAT_2, 1'b1);
      taken.delete();
      issue(SBO_CMD_WRITE, 2'h0, 12'h006);
      chk({array_valid, array_write, burst_busy}, 3'h6);
      wait_idle();
      chk(taken.size(), 1);
      chk(taken[0], 9'h006);
      rd(2'h0, 9'h006, MASK_8, 1'b0, 2, 8);
      // Close bank 0, prove it refuses reads, then open a different row there
      issue(SBO_CMD_PRECHARGE, 2'h0, 12'h000);
      chk(bank_open, 4'h2);
      issue(SBO_CMD_READ, 2'h0, 12'h000);
      chk(cmd_error, 1'b1);
      rows[0] = 12'h3c9;
      repeat (10) @(negedge clk);
      issue(SBO_CMD_ACTIVE, 2'h0, rows[0]);
      repeat (3) @(negedge clk);
      chk(bank_open, 4'h3);
      rd(2'h0, 9'h0e2, MASK_8, 1'b0, 2, 8);
      wrap_up();
   end
endmodule
bind sbo_core sbo_core_asserts u_chk (.clk, .rstn, .cmd, .cmd_bank, .cmd_addr, .array_valid,
   .array_ready, .array_col, .dq_oe_n, .mode_value, .bank_open, .burst_busy, .cmd_error);
`default_nettype wire
